// [common/fdcs_pkg.sv]
// fdcs_pkg: shared constants, encodings and carrier types for the floppy
// command/status block; assumes an 8-bit register port and a 40 MHz clock.
package fdcs_pkg;
    localparam logic [3:0] FDCS_OFS_CMD_STAT = 4'h0;
    localparam logic [3:0] FDCS_OFS_TRACK = 4'h2;
    localparam logic [3:0] FDCS_OFS_SECTOR = 4'h4;
    localparam logic [3:0] FDCS_OFS_DATA = 4'h6;
    localparam logic [3:0] FDCS_OFS_DRVCTL = 4'h8;

    localparam int FDCS_CLK_HZ = 40000000;
    localparam int FDCS_DELAY_FAST_MS = 15;
    localparam int FDCS_DELAY_SLOW_MS = 30;
    localparam int FDCS_MS_CYC = FDCS_CLK_HZ / 1000;
    localparam logic [15:0] FDCS_MS_CNT = 16'(FDCS_MS_CYC - 1);
    // byte interval allowed for the host to answer a data request
    localparam int FDCS_BYTE_US = 16;
    localparam logic [15:0] FDCS_BYTE_CYC = 16'(FDCS_BYTE_US * 40);
    localparam int FDCS_RATE_MS0 = 6;
    localparam int FDCS_RATE_MS1 = 12;
    localparam int FDCS_RATE_MS2 = 20;
    localparam int FDCS_RATE_MS3 = 30;

    localparam logic [7:0] FDCS_MARK_NORMAL = 8'hfb;
    localparam logic [7:0] FDCS_MARK_DELETED = 8'hf8;
    localparam logic [7:0] FDCS_DRVCTL_RST = 8'h00;
    localparam int FDCS_DRV_EN_BIT = 0;
    localparam int FDCS_MOTOR_BIT = 2;

    typedef enum logic [3:0] {
        FDCS_C_RESTORE = 4'h0,
        FDCS_C_SEEK = 4'h1,
        FDCS_C_STEP = 4'h2,
        FDCS_C_STEP_IN = 4'h3,
        FDCS_C_STEP_OUT = 4'h4,
        FDCS_C_RD_SEC = 4'h5,
        FDCS_C_WR_SEC = 4'h6,
        FDCS_C_RD_ADR = 4'h7,
        FDCS_C_RD_TRK = 4'h8,
        FDCS_C_WR_TRK = 4'h9,
        FDCS_C_FORCE = 4'ha,
        FDCS_C_NONE = 4'hf
    } fdcs_cmd_t;

    // decoded command with its option flags
    typedef struct packed {
        fdcs_cmd_t cmd;
        logic track_update;
        logic head_load;
        logic verify;
        logic [1:0] step_rate_field;
        logic multi_record;
        logic long_sizes;
        logic delay_en;
        logic side_sel;
        logic data_mark_select;
        logic [3:0] interrupt_condition_bits;
    } fdcs_dec_t;

    // events from the disk-side datapath
    typedef struct packed {
        logic byte_ready;
        logic [7:0] byte_val;
        logic id_crc_err;
        logic data_crc_err;
        logic not_found;
        logic deleted_mark;
        logic seek_fail;
        logic done;
    } fdcs_disk_t;
endpackage

// [hw/fdcs_decode.sv]
// fdcs_decode: turns a command byte into a decoded command with flags.
// assumes the byte is stable while sampled; purely combinational.
`timescale 1ns/1ps
module fdcs_decode
    import fdcs_pkg::*;
(
    input wire logic [7:0] cmd_byte,
    output fdcs_dec_t dec
);
    fdcs_cmd_t c;
    assign c = (cmd_byte[7:4] == 4'h0) ? FDCS_C_RESTORE :
               (cmd_byte[7:4] == 4'h1) ? FDCS_C_SEEK :
               (cmd_byte[7:5] == 3'h1) ? FDCS_C_STEP :
               (cmd_byte[7:5] == 3'h2) ? FDCS_C_STEP_IN :
               (cmd_byte[7:5] == 3'h3) ? FDCS_C_STEP_OUT :
               (cmd_byte[7:5] == 3'h4) ? FDCS_C_RD_SEC :
               (cmd_byte[7:5] == 3'h5) ? FDCS_C_WR_SEC :
               (cmd_byte[7:3] == 5'h18) ? FDCS_C_RD_ADR :
               (cmd_byte[7:3] == 5'h1c) ? FDCS_C_RD_TRK :
               (cmd_byte[7:3] == 5'h1e) ? FDCS_C_WR_TRK :
               (cmd_byte[7:4] == 4'hd) ? FDCS_C_FORCE :
               FDCS_C_NONE;
    assign dec.cmd = c;
    assign dec.track_update = cmd_byte[4];
    assign dec.head_load = cmd_byte[3];
    assign dec.verify = cmd_byte[2];
    assign dec.step_rate_field = cmd_byte[1:0];
    assign dec.multi_record = cmd_byte[4];
    assign dec.long_sizes = cmd_byte[3];
    assign dec.delay_en = cmd_byte[2];
    assign dec.side_sel = cmd_byte[1];
    assign dec.data_mark_select = cmd_byte[0];
    assign dec.interrupt_condition_bits = cmd_byte[3:0];
endmodule // fdcs_decode

// [hw/fdcs_ms_timer.sv]
// fdcs_ms_timer: counts whole milliseconds after a start pulse.
// assumes one 40 MHz clock; done pulses one cycle at the end.
`timescale 1ns/1ps
module fdcs_ms_timer
    import fdcs_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic start,
    input wire logic abort,
    input wire logic [7:0] ms,
    output logic busy,
    output logic done
);
    logic [15:0] sub_q;
    logic [7:0] left_q;
    logic tick;
    assign tick = busy && (sub_q == FDCS_MS_CNT);
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sub_q <= 16'h0000;
            left_q <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                busy <= 1'b0;
            end else if (start) begin
                sub_q <= 16'h0000;
                left_q <= ms;
                busy <= (ms != 8'h00);
                done <= (ms == 8'h00);
            end else if (busy) begin
                sub_q <= tick ? 16'h0000 : sub_q + 16'h0001;
                if (tick) begin
                    left_q <= left_q - 8'h01;
                    if (left_q == 8'h01) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                end
            end
        end
    end
endmodule // fdcs_ms_timer

// [hw/fdcs_core.sv]
// What this block does
// - positioning commands decoded from upper bits
// - transfer and force interrupt commands decoded
// - verify, head-load, track-update flags obeyed
// - length flag selects sector size mapping
// - multiple-record flag continues across records
// - data-mark flag picks fb or f8
// - side select output follows command flag
// - delay flag inserts 15 or 30 ms
// - force interrupt conditions raise interrupt
// - status bit 0 shows busy
// - type 1 bits 1,2,6 invert drive inputs
// - type 1 crc and seek error bits
// - head loaded is head-load and timing
// - not ready bit; transfers need ready
// - transfer status bit 1 mirrors data request
// - unserviced request sets lost data
// - record not found and crc error bits
// - record type from mark; writes zero
// - track register steps and compares
// - sector register written and read back by the host only
// - data register exchanges bytes with shifter
// - drive control enables drive and motor
// - busy on accept, interrupt on completion
// - status and command share offset zero
//
// fdcs_core: host registers, command sequencing and status of the floppy
// controller; assumes a synchronous 8-bit register port and a disk-side
// datapath that reports bytes, marks and errors through disk_ev.
`timescale 1ns/1ps
module fdcs_core
    import fdcs_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic drive_ready_in,
    input wire logic index_pulse_in_b,
    input wire logic track_zero_in_b,
    input wire logic write_protect_in_b,
    input wire logic head_load_timing_in,
    input wire logic master_reset_in_b,
    input wire logic slow_clock_sel,
    input wire fdcs_disk_t disk_ev,
    output logic intr_q,
    output logic data_request_out,
    output logic head_load_out,
    output logic side_select_output,
    output logic step_q,
    output logic dir_in_q,
    output logic drive_en_q,
    output logic motor_on_q,
    output logic [7:0] shift_out_q,
    output logic shift_load_q,
    output logic [7:0] write_mark_q,
    output logic [10:0] sector_size_q,
    output logic multi_q
);
    typedef enum logic [2:0] {
        FDCS_S_IDLE = 3'b000,
        FDCS_S_DELAY = 3'b001,
        FDCS_S_STEP = 3'b010,
        FDCS_S_SETTLE = 3'b011,
        FDCS_S_XFER = 3'b100
    } fdcs_state_t;

    fdcs_state_t state_q, state_d;
    fdcs_dec_t dec, cur_q;
    logic [7:0] track_q, sector_q, data_q, drvctl_q;
    logic busy_q, drq_q, lost_q, crc_q, rnf_q, rtype_q, seek_q;
    logic type1_q, cmd_wr, force_wr, accept, is_t1, is_t23, xfer_done;
    logic rdy_q, idx_q, armed_q, in_xfer_q;
    logic [15:0] byte_tmr_q;
    logic [7:0] target_q;
    logic [7:0] tmr_ms;
    logic tmr_start, tmr_busy, tmr_done;
    logic at_target, step_out, is_write;

    fdcs_decode u_dec (
        .cmd_byte(reg_wdata),
        .dec(dec)
    );
    fdcs_ms_timer u_tmr (
        .clock(clock),
        .rst_b(rst_b),
        .start(tmr_start),
        .abort(force_wr),
        .ms(tmr_ms),
        .busy(tmr_busy),
        .done(tmr_done)
    );
    function automatic logic [7:0] rate_ms(input logic [1:0] r);
        unique case (r)
            2'b00: rate_ms = 8'(FDCS_RATE_MS0);
            2'b01: rate_ms = 8'(FDCS_RATE_MS1);
            2'b10: rate_ms = 8'(FDCS_RATE_MS2);
            2'b11: rate_ms = 8'(FDCS_RATE_MS3);
        endcase
    endfunction
    // size of a sector for a length code, under either mapping
    function automatic logic [10:0] size_of(input logic lng,
                                            input logic [1:0] code);
        logic [1:0] k;
        k = lng ? code : code + 2'b01;
        size_of = 11'h080 << k;
    endfunction

    assign cmd_wr = reg_wr && (reg_addr == FDCS_OFS_CMD_STAT);
    assign force_wr = cmd_wr && (dec.cmd == FDCS_C_FORCE);
    assign is_t1 = (dec.cmd <= FDCS_C_STEP_OUT);
    assign is_t23 = (dec.cmd >= FDCS_C_RD_SEC) && (dec.cmd <= FDCS_C_WR_TRK);
    // host keeps off commands while busy; type 2/3 refused when not ready
    assign accept = cmd_wr && !busy_q && (is_t1
                    || (is_t23 && drive_ready_in));
    assign is_write = (cur_q.cmd == FDCS_C_WR_SEC)
                      || (cur_q.cmd == FDCS_C_WR_TRK);
    assign at_target = (track_q == target_q);
    assign step_out = (cur_q.cmd == FDCS_C_STEP_OUT)
                      || (cur_q.cmd == FDCS_C_RESTORE)
                      || (((cur_q.cmd == FDCS_C_SEEK)
                      || (cur_q.cmd == FDCS_C_STEP)) && (target_q < track_q));
    assign xfer_done = disk_ev.done && !(cur_q.multi_record
                       && (cur_q.cmd <= FDCS_C_WR_SEC)
                       && (cur_q.cmd >= FDCS_C_RD_SEC));
    assign tmr_start = (accept && is_t23 && dec.delay_en)
                       || (state_q == FDCS_S_STEP);
    assign tmr_ms = (state_q == FDCS_S_STEP) ? rate_ms(cur_q.step_rate_field)
                    : slow_clock_sel ? 8'(FDCS_DELAY_SLOW_MS)
                    : 8'(FDCS_DELAY_FAST_MS);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            FDCS_S_IDLE:
                if (accept) begin
                    state_d = is_t1 ? FDCS_S_SETTLE
                              : dec.delay_en ? FDCS_S_DELAY : FDCS_S_XFER;
                end
            FDCS_S_DELAY:
                if (tmr_done) begin
                    state_d = FDCS_S_XFER;
                end
            FDCS_S_SETTLE:
                if (!tmr_busy) begin
                    state_d = (at_target || (cur_q.cmd == FDCS_C_RESTORE
                               && !track_zero_in_b)) ? FDCS_S_IDLE
                              : FDCS_S_STEP;
                end
            FDCS_S_STEP:
                state_d = FDCS_S_SETTLE;
            FDCS_S_XFER:
                if (xfer_done) begin
                    state_d = FDCS_S_IDLE;
                end
            default:
                state_d = FDCS_S_IDLE;
        endcase
        if (force_wr) begin
            state_d = FDCS_S_IDLE;
        end
    end

    // status byte: type 1 shows drive lines, type 2/3 transfer results
    logic [7:0] status;
    assign status[0] = busy_q;
    assign status[1] = type1_q ? !index_pulse_in_b : drq_q;
    assign status[2] = type1_q ? !track_zero_in_b : lost_q;
    assign status[3] = crc_q;
    assign status[4] = type1_q ? seek_q : rnf_q;
    assign status[5] = type1_q ? (head_load_out && head_load_timing_in)
                       : (rtype_q && !is_write);
    assign status[6] = (type1_q || is_write) ? !write_protect_in_b
                       : 1'b0;
    assign status[7] = !drive_ready_in || !master_reset_in_b;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= FDCS_S_IDLE;
            cur_q <= '0;
            busy_q <= 1'b0;
            type1_q <= 1'b1;
        end else begin
            state_q <= state_d;
            if (accept || force_wr) begin
                cur_q <= dec;
                type1_q <= force_wr ? type1_q : is_t1;
            end
            busy_q <= (state_d != FDCS_S_IDLE);
        end
    end

    // completion and forced-interrupt events
    logic rdy_rise, rdy_fall, idx_edge, done_evt;
    assign rdy_rise = drive_ready_in && !rdy_q;
    assign rdy_fall = !drive_ready_in && rdy_q;
    assign idx_edge = !index_pulse_in_b && idx_q;
    assign done_evt = busy_q && (state_d == FDCS_S_IDLE) && !force_wr;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            intr_q <= 1'b0;
            armed_q <= 1'b0;
            rdy_q <= 1'b0;
            idx_q <= 1'b1;
        end else begin
            rdy_q <= drive_ready_in;
            idx_q <= index_pulse_in_b;
            if (force_wr) begin
                armed_q <= dec.interrupt_condition_bits[3];
                intr_q <= dec.interrupt_condition_bits[3];
            end else if (done_evt) begin
                intr_q <= 1'b1;
            end else if ((cur_q.cmd == FDCS_C_FORCE) && (armed_q
                         || |(cur_q.interrupt_condition_bits[2:0]
                         & {idx_edge, rdy_fall, rdy_rise}))) begin
                intr_q <= 1'b1;
            end else if ((reg_rd && reg_addr == FDCS_OFS_CMD_STAT)
                         || accept) begin
                intr_q <= 1'b0;
            end
        end
    end

    // error flags: cleared on a new command, events win over the clear
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            crc_q <= 1'b0;
            rnf_q <= 1'b0;
            rtype_q <= 1'b0;
            seek_q <= 1'b0;
            lost_q <= 1'b0;
        end else begin
            crc_q <= (crc_q && !accept) || disk_ev.id_crc_err
                     || (disk_ev.data_crc_err && !type1_q);
            rnf_q <= (rnf_q && !accept) || disk_ev.not_found;
            rtype_q <= (rtype_q && !accept) || disk_ev.deleted_mark;
            seek_q <= (seek_q && !accept) || (disk_ev.seek_fail
                      && cur_q.verify);
            lost_q <= (lost_q && !accept) || (drq_q && busy_q
                      && (byte_tmr_q == FDCS_BYTE_CYC));
        end
    end

    // data request handshake and byte-interval watchdog
    logic data_acc;
    assign data_acc = (reg_rd || reg_wr) && (reg_addr == FDCS_OFS_DATA);
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            drq_q <= 1'b0;
            byte_tmr_q <= 16'h0000;
            in_xfer_q <= 1'b0;
        end else begin
            in_xfer_q <= (state_q == FDCS_S_XFER);
            if ((state_q == FDCS_S_XFER) && (disk_ev.byte_ready
                || (is_write && (!in_xfer_q || shift_load_q)))) begin
                drq_q <= 1'b1;
            end else if (data_acc || !busy_q) begin
                drq_q <= 1'b0;
            end
            byte_tmr_q <= (drq_q && byte_tmr_q != FDCS_BYTE_CYC)
                          ? byte_tmr_q + 16'h0001 : 16'h0000;
        end
    end

    // host-visible registers
    logic seek_data;
    assign seek_data = accept && (dec.cmd == FDCS_C_SEEK);
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            track_q <= 8'h00;
            sector_q <= 8'h00;
            data_q <= 8'h00;
            drvctl_q <= FDCS_DRVCTL_RST;
            target_q <= 8'h00;
            shift_out_q <= 8'h00;
            shift_load_q <= 1'b0;
        end else begin
            shift_load_q <= 1'b0;
            if (reg_wr && reg_addr == FDCS_OFS_TRACK) begin
                track_q <= reg_wdata;
            end else if (state_q == FDCS_S_STEP && (cur_q.track_update
                         || cur_q.cmd == FDCS_C_SEEK
                         || cur_q.cmd == FDCS_C_RESTORE)) begin
                track_q <= step_out ? track_q - 8'h01
                           : track_q + 8'h01;
            end
            if (reg_wr && reg_addr == FDCS_OFS_SECTOR) begin
                sector_q <= reg_wdata;
            end
            if (reg_wr && reg_addr == FDCS_OFS_DATA) begin
                data_q <= reg_wdata;
                shift_out_q <= reg_wdata;
                shift_load_q <= is_write;
            end else if (disk_ev.byte_ready) begin
                data_q <= disk_ev.byte_val;
            end
            if (reg_wr && reg_addr == FDCS_OFS_DRVCTL) begin
                drvctl_q <= reg_wdata;
            end
            if (accept) begin
                unique case (dec.cmd)
                    FDCS_C_SEEK: target_q <= data_q;
                    FDCS_C_RESTORE: target_q <= 8'h00;
                    FDCS_C_STEP_IN: target_q <= track_q + 8'h01;
                    FDCS_C_STEP_OUT: target_q <= track_q - 8'h01;
                    FDCS_C_STEP: target_q <= dir_in_q ? track_q + 8'h01
                                                      : track_q - 8'h01;
                    default: target_q <= target_q;
                endcase
            end else if (state_q == FDCS_S_STEP && !cur_q.track_update
                         && cur_q.cmd != FDCS_C_SEEK
                         && cur_q.cmd != FDCS_C_RESTORE) begin
                target_q <= track_q; // steps without track update
            end
        end
    end

    // drive-facing outputs
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            head_load_out <= 1'b0;
            side_select_output <= 1'b0;
            step_q <= 1'b0;
            dir_in_q <= 1'b0;
            drive_en_q <= 1'b0;
            motor_on_q <= 1'b0;
            write_mark_q <= FDCS_MARK_NORMAL;
            sector_size_q <= 11'h100;
            multi_q <= 1'b0;
            reg_rdata <= 8'h00;
            data_request_out <= 1'b0;
        end else begin
            step_q <= (state_q == FDCS_S_STEP);
            if (state_q == FDCS_S_STEP) begin
                dir_in_q <= !step_out;
            end
            drive_en_q <= drvctl_q[FDCS_DRV_EN_BIT];
            motor_on_q <= drvctl_q[FDCS_MOTOR_BIT];
            data_request_out <= drq_q;
            if (accept) begin
                if (is_t1) begin
                    head_load_out <= dec.head_load;
                end else begin
                    head_load_out <= 1'b1;
                    side_select_output <= dec.side_sel;
                    multi_q <= dec.multi_record;
                    sector_size_q <= size_of(dec.long_sizes,
                                             disk_ev.byte_val[1:0]);
                    write_mark_q <= dec.data_mark_select
                                    ? FDCS_MARK_DELETED
                                    : FDCS_MARK_NORMAL;
                end
            end
            unique case (reg_addr)
                FDCS_OFS_CMD_STAT: reg_rdata <= status;
                FDCS_OFS_TRACK: reg_rdata <= track_q;
                FDCS_OFS_SECTOR: reg_rdata <= sector_q;
                FDCS_OFS_DATA: reg_rdata <= data_q;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule // fdcs_core

// [bench/fdcs_disk_model.sv]
// fdcs_disk_model: disk-side datapath stand-in that feeds disk_ev.
// assumes the bench requests the end of a transfer with a one-cycle pulse.
`timescale 1ns/1ps
module fdcs_disk_model
    import fdcs_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic finish,
    input wire logic deleted,
    output fdcs_disk_t ev
);
    // no bytes are ever offered, so only an idle write transfer shows as lost data
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ev <= '0;
        end else begin
            ev.deleted_mark <= finish && deleted;
            ev.done <= ev.deleted_mark || (finish && !deleted);
        end
    end
endmodule // fdcs_disk_model

// [bench/fdcs_chk.sv]
// fdcs_chk: port-level assertions for fdcs_core.
// assumes one clock domain and read data that lags its offset by one edge.
`timescale 1ns/1ps
module fdcs_chk
    import fdcs_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic drive_ready_in,
    input wire logic master_reset_in_b,
    input wire logic step_q,
    input wire logic side_select_output,
    input wire logic drive_en_q,
    input wire logic motor_on_q,
    input wire logic [7:0] write_mark_q,
    input wire logic [10:0] sector_size_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_unmapped_zero: assert property (
        !($past(reg_addr) inside {0, 2, 4, 6}) |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_not_ready: assert property ($past(reg_addr) == 4'h0 |->
        reg_rdata[7] == $past(!drive_ready_in || !master_reset_in_b))
        else $error("not ready bit wrong");
    a_mark_legal: assert property (write_mark_q inside {8'hfb, 8'hf8})
        else $error("bad data mark");
    a_size_legal: assert property (
        sector_size_q inside {128, 256, 512, 1024})
        else $error("bad sector size");
    // drive lines follow the control register one edge after it loads
    a_drvctl_wr: assert property (reg_wr && reg_addr == 4'h8 |-> ##2
        drive_en_q == $past(reg_wdata[0], 2)
        && motor_on_q == $past(reg_wdata[2], 2))
        else $error("drive control not applied");
    a_step_pulse: assert property (step_q |=> !step_q)
        else $error("step longer than a cycle");
    a_track_back: assert property (reg_wr && reg_addr == 4'h2 ##1
        reg_addr == 4'h2 && !step_q |=> reg_rdata == $past(reg_wdata, 2))
        else $error("track readback wrong");
    a_side_follow: assert property ($changed(side_select_output) |->
        $past(reg_wr && reg_addr == 4'h0 && reg_wdata[7])
        && $past(reg_wdata[1]) == side_select_output)
        else $error("side select moved on its own");
    c_step: cover property (step_q);
    c_drvctl: cover property (reg_wr && reg_addr == 4'h8);
    c_side: cover property ($rose(side_select_output));
    c_deleted: cover property (write_mark_q == 8'hf8);
endmodule // fdcs_chk
bind fdcs_core fdcs_chk u_chk (.*);

// [bench/testbench.sv]
// testbench: register rows, then command, refusal and status scenarios.
// assumes drive levels are set by the bench and disk events by the model.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
    $display("MISMATCH t=%0t value differs", $time); end end
module testbench;
    import fdcs_pkg::*;
    logic clock = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, rdy = 1, mr_b = 1;
    logic ip_b = 1, tz_b = 0, wp_b = 1, hlt = 0, fin = 0, del = 0;
    logic [3:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata, d, wm, so;
    logic [10:0] ssz;
    logic intr, drq, hld, side, stp, dir, den, mot, sl, mul;
    fdcs_disk_t ev;
    int failures = 0, n_tests = 0;
    logic [19:0] rows [5] = '{20'h24c4c, 20'h41010, 20'h65a5a, 20'h80500,
        20'ha3300};
    fdcs_disk_model u_mdl (.clock(clock), .rst_b(rst_b), .finish(fin),
        .deleted(del), .ev(ev));
    fdcs_core DUT (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .drive_ready_in(rdy), .index_pulse_in_b(ip_b),
        .track_zero_in_b(tz_b), .write_protect_in_b(wp_b),
        .head_load_timing_in(hlt), .master_reset_in_b(mr_b),
        .slow_clock_sel(1'b0), .disk_ev(ev), .intr_q(intr),
        .data_request_out(drq), .head_load_out(hld),
        .side_select_output(side), .step_q(stp), .dir_in_q(dir),
        .drive_en_q(den), .motor_on_q(mot), .shift_out_q(so),
        .shift_load_q(sl), .write_mark_q(wm), .sector_size_q(ssz),
        .multi_q(mul));
    initial forever #12.5 clock = ~clock;
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock) #2 reg_addr = a;
        reg_wdata = v;
        reg_wr = 1;
        @(posedge clock) #2 reg_wr = 0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clock) #2 reg_addr = a;
        reg_rd = 1;
        @(posedge clock) #2 reg_rd = 0;
        d = reg_rdata;
    endtask
    task automatic finish_xfer(input logic dm);
        @(posedge clock) #2 del = dm;
        fin = 1;
        @(posedge clock) #2 fin = 0;
    endtask
    task automatic wint();
        for (int i = 0; i < 3000 && intr !== 1'b1; i++) begin
            @(posedge clock);
            #2;
        end
        `CHK(intr, 1'b1)
    endtask
    task automatic complete_run();
        if (failures == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #(25 * 30000);
        failures++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge clock);
        #2 rst_b = 1;
        `CHK({wm, ssz, intr, den}, {8'hfb, 11'd256, 2'b00})
        rd(0);
        `CHK(d, 8'h04)
        mr_b = 0;
        rd(0);
        `CHK(d[7], 1'b1)
        mr_b = 1;
        foreach (rows[i]) begin
            wr(rows[i][19:16], rows[i][15:8]);
            rd(rows[i][19:16]);
            `CHK(d, rows[i][7:0])
        end
        `CHK({den, mot}, 2'b11)
        wr(0, 8'h00);
        wint();
        rd(0);
        `CHK({d[2], d[0], intr}, 3'b100)
        wr(0, 8'h58);
        repeat (2) @(posedge clock);
        #2 `CHK({stp, dir, hld}, 3'b111)
        hlt = 1;
        rd(0);
        `CHK({d[5], d[0]}, 2'b11)
        wr(0, 8'hd0);
        rd(2);
        `CHK(d, 8'h4d)
        rdy = 0;
        wr(0, 8'h80);
        rd(0);
        `CHK({d[7], d[0]}, 2'b10)
        rdy = 1;
        wr(0, 8'hc8);
        rd(0);
        `CHK(d[0], 1'b0)
        wr(0, 8'ha3);
        rd(0);
        `CHK({d[0], wm, side, mul}, {1'b1, 8'hf8, 2'b10})
        `CHK({d[1], drq}, 2'b11)
        repeat (700) @(posedge clock);
        rd(0);
        `CHK({d[5], d[2]}, 2'b01)
        wr(6, 8'h3c);
        `CHK({so, sl}, {8'h3c, 1'b1})
        finish_xfer(0);
        wint();
        wr(0, 8'h98);
        `CHK({mul, ssz}, {1'b1, 11'd128})
        finish_xfer(1);
        repeat (4) @(posedge clock);
        rd(0);
        `CHK({d[5], d[0]}, 2'b11)
        wr(0, 8'hd0);
        rd(0);
        `CHK({d[5], d[0], intr}, 3'b100)
        wr(0, 8'h80);
        wr(0, 8'hd0);
        repeat (4) @(posedge clock);
        rd(0);
        `CHK({d[0], intr}, 2'b00)
        wr(0, 8'hd8);
        repeat (4) @(posedge clock);
        `CHK(intr, 1'b1)
        complete_run();
    end
endmodule // testbench
